// [rtl/atof_pkg.sv]
// Package for the acceleration and temperature output formatter
package atof_pkg;
  // ----------------------------------------
  // Register offsets (register port address)
  // ----------------------------------------
  localparam logic [7:0] ACC_X_LOW_ADDR = 8'h04;
  localparam logic [7:0] ACC_X_HIGH_ADDR = 8'h05;
  localparam logic [7:0] ACC_Y_LOW_ADDR = 8'h06;
  localparam logic [7:0] ACC_Y_HIGH_ADDR = 8'h07;
  localparam logic [7:0] ACC_Z_LOW_ADDR = 8'h08;
  localparam logic [7:0] ACC_Z_HIGH_ADDR = 8'h09;
  localparam logic [7:0] TEMP_LOW_ADDR = 8'h12;
  localparam logic [7:0] TEMP_HIGH_ADDR = 8'h13;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // ----------------------------------------
  // Encoding constants
  // ----------------------------------------
  localparam int ACC_REDUCED_SHIFT = 4;
  localparam int ACC_HIRES_SHIFT = 2;
  localparam logic signed [15:0] HIRES_POS_LIMIT = 16'sh0fff;
  localparam logic signed [15:0] HIRES_NEG_LIMIT = -16'sh1000;
  localparam logic [15:0] CHECKSUM_FAIL_WORD = 16'h7fff;
  localparam logic [15:0] SELFTEST_FAIL_WORD = 16'hffff;
  localparam logic [15:0] TEMP_HIRES_NOMINAL = 16'h0200;
  localparam int NUM_AXES = 3;

  // Range and flavour selection
  typedef enum logic [1:0] {
    ATOF_SIX_REDUCED = 2'b00,
    ATOF_SIX_HIRES = 2'b01,
    ATOF_ONE_G = 2'b10
  } atof_mode_type;

  // Checksum and self-test alarm flags
  typedef struct packed {
    logic checksumFail;
    logic continuousSelftestFail;
    logic startupSelftestFail;
  } atof_alarm_type;

  // Register read request
  typedef struct packed {
    logic rdStrobe;
    logic [7:0] rdAddr;
  } atof_rd_type;
endpackage

// [rtl/atof_hold_mem.sv]
// Holding store for captured low bytes, one per slot, registered read
`timescale 1ns/1ps
module atof_hold_mem (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [1:0] wrIdx,
  input wire logic [7:0] wrData,
  input wire logic [1:0] rdIdx,
  output logic [7:0] rdData
);
  logic [7:0] mem_reg [4];
  logic [7:0] mem_next [4];
  logic [7:0] rdData_next;

  // Next contents: only the written slot changes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mem_next[i] = (wrEn && wrIdx == 2'(i)) ? wrData : mem_reg[i];
    end
    rdData_next = mem_reg[rdIdx];
  end

  // Storage registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        mem_reg[i] <= atof_pkg::BYTE_RESET;
      end
      rdData <= atof_pkg::BYTE_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rdData <= rdData_next;
    end
  end
endmodule

// [rtl/atof_formatter.sv]
// Output formatter with coherent high/low byte reads for acceleration and temperature
`timescale 1ns/1ps
module atof_formatter (
  input wire logic ref_clk,
  input wire logic nrst,
  input atof_pkg::atof_mode_type mode,
  input atof_pkg::atof_alarm_type alarm,
  input wire logic sampleValid,
  input wire logic signed [15:0] accX,
  input wire logic signed [15:0] accY,
  input wire logic signed [15:0] accZ,
  input wire logic signed [13:0] tempRaw,
  input atof_pkg::atof_rd_type rdReq,
  output logic [7:0] rdData,
  output logic rdValid
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Slot index of an address pair, 3 for temperature
  function automatic logic [1:0] slot_of(input logic [7:0] a);
    unique case (a)
      atof_pkg::ACC_X_LOW_ADDR, atof_pkg::ACC_X_HIGH_ADDR: slot_of = 2'h0;
      atof_pkg::ACC_Y_LOW_ADDR, atof_pkg::ACC_Y_HIGH_ADDR: slot_of = 2'h1;
      atof_pkg::ACC_Z_LOW_ADDR, atof_pkg::ACC_Z_HIGH_ADDR: slot_of = 2'h2;
      default: slot_of = 2'h3;
    endcase
  endfunction

  // True for any high-byte address
  function automatic logic is_high(input logic [7:0] a);
    is_high = (a == atof_pkg::ACC_X_HIGH_ADDR) || (a == atof_pkg::ACC_Y_HIGH_ADDR) ||
              (a == atof_pkg::ACC_Z_HIGH_ADDR) || (a == atof_pkg::TEMP_HIGH_ADDR);
  endfunction

  // True for any low-byte address
  function automatic logic is_low(input logic [7:0] a);
    is_low = (a == atof_pkg::ACC_X_LOW_ADDR) || (a == atof_pkg::ACC_Y_LOW_ADDR) ||
             (a == atof_pkg::ACC_Z_LOW_ADDR) || (a == atof_pkg::TEMP_LOW_ADDR);
  endfunction

  // Encode one acceleration sample for the selected range
  function automatic logic [15:0] enc_acc(input logic signed [15:0] v, input atof_pkg::atof_mode_type m,
                                          input atof_pkg::atof_alarm_type al);
    logic signed [15:0] c;
    c = v;
    if (m == atof_pkg::ATOF_SIX_HIRES) begin
      if (v > atof_pkg::HIRES_POS_LIMIT) c = atof_pkg::HIRES_POS_LIMIT;
      else if (v < atof_pkg::HIRES_NEG_LIMIT) c = atof_pkg::HIRES_NEG_LIMIT;
    end
    unique case (m)
      atof_pkg::ATOF_SIX_REDUCED: enc_acc = {v[11:0], 4'h0};
      atof_pkg::ATOF_SIX_HIRES: enc_acc = {c[13:0], 2'h0};
      default: enc_acc = v;
    endcase
    if (al.checksumFail) enc_acc = atof_pkg::CHECKSUM_FAIL_WORD;
    if (al.continuousSelftestFail || al.startupSelftestFail) enc_acc = atof_pkg::SELFTEST_FAIL_WORD;
  endfunction

  // ----------------------------------------
  // Live sample words
  // ----------------------------------------
  logic [15:0] liveWord [4];
  logic [15:0] tempWord;

  // Temperature layout per flavour; sensor code for high-res is unsigned
  always_comb begin
    if (mode == atof_pkg::ATOF_SIX_HIRES) begin
      tempWord = {2'h0, tempRaw[12:0], 1'b0};
    end else begin
      tempWord = {2'h0, tempRaw};
    end
  end

  // Latest samples, updated when a new sample arrives
  logic [15:0] sample_reg [4];
  logic [15:0] sample_next [4];

  genvar g;
  generate
    for (g = 0; g < atof_pkg::NUM_AXES; g++) begin : gAxis
      logic signed [15:0] axIn;
      assign axIn = (g == 0) ? accX : ((g == 1) ? accY : accZ);
      assign liveWord[g] = enc_acc(axIn, mode, alarm);
    end
  endgenerate
  assign liveWord[3] = tempWord;

  // Sample update logic
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sample_next[i] = sampleValid ? liveWord[i] : sample_reg[i];
    end
  end

  // Sample registers, reset to zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        sample_reg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        sample_reg[i] <= sample_next[i];
      end
    end
  end

  // ----------------------------------------
  // Read decode and low-byte capture
  // ----------------------------------------
  logic rdHigh;
  logic rdLow;
  logic [1:0] rdSlot;
  logic [7:0] holdData;

  assign rdHigh = rdReq.rdStrobe && is_high(rdReq.rdAddr);
  assign rdLow = rdReq.rdStrobe && is_low(rdReq.rdAddr);
  assign rdSlot = slot_of(rdReq.rdAddr);

  // Captured low bytes, written only on a high-byte read
  atof_hold_mem uHold (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wrEn(rdHigh),
    .wrIdx(rdSlot),
    .wrData(sample_reg[rdSlot][7:0]),
    .rdIdx(rdSlot),
    .rdData(holdData)
  );

  // Answer pipeline: memory read lands one cycle after the strobe
  logic pendValid_reg;
  logic pendValid_next;
  logic pendLow_reg;
  logic pendLow_next;
  logic pendMapped_reg;
  logic pendMapped_next;
  logic [7:0] highByte_reg;
  logic [7:0] highByte_next;

  // Next answer state
  always_comb begin
    pendValid_next = rdReq.rdStrobe;
    pendLow_next = rdLow;
    pendMapped_next = rdHigh || rdLow;
    highByte_next = rdHigh ? sample_reg[rdSlot][15:8] : atof_pkg::UNMAPPED_DATA;
  end

  // Answer registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pendValid_reg <= 1'b0;
      pendLow_reg <= 1'b0;
      pendMapped_reg <= 1'b0;
      highByte_reg <= atof_pkg::BYTE_RESET;
    end else begin
      pendValid_reg <= pendValid_next;
      pendLow_reg <= pendLow_next;
      pendMapped_reg <= pendMapped_next;
      highByte_reg <= highByte_next;
    end
  end

  // Read data mux; low byte always from the capture store
  assign rdValid = pendValid_reg;
  assign rdData = !pendMapped_reg ? atof_pkg::UNMAPPED_DATA : (pendLow_reg ? holdData : highByte_reg);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_high_read;
    rdHigh;
  endsequence

  a_high_captures_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_high_read ##1 (rdReq.rdStrobe && is_low(rdReq.rdAddr) && slot_of(rdReq.rdAddr) == $past(rdSlot))
      |=> rdData == $past(sample_reg[rdSlot][7:0], 2))
    else $error("low byte not coherent with high byte");
  a_read_answer_one: assert property (@(posedge ref_clk) disable iff (!nrst)
    rdReq.rdStrobe |=> rdValid)
    else $error("read answer missing");
  a_alarm_forces_ffff: assert property (@(posedge ref_clk) disable iff (!nrst)
    (alarm.continuousSelftestFail && sampleValid) |=> sample_reg[0] == atof_pkg::SELFTEST_FAIL_WORD)
    else $error("self-test alarm not forced");
  a_checksum_forces: assert property (@(posedge ref_clk) disable iff (!nrst)
    (alarm.checksumFail && !alarm.continuousSelftestFail && !alarm.startupSelftestFail && sampleValid)
      |=> sample_reg[1] == atof_pkg::CHECKSUM_FAIL_WORD)
    else $error("checksum alarm not forced");
  a_reduced_low_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sampleValid && mode == atof_pkg::ATOF_SIX_REDUCED && alarm == '0)
      |=> sample_reg[2][3:0] == 4'h0 && sample_reg[2][15:4] == $past(accZ[11:0]))
    else $error("reduced six-g layout wrong");
  a_hires_clamp: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sampleValid && mode == atof_pkg::ATOF_SIX_HIRES && alarm == '0 && accX > atof_pkg::HIRES_POS_LIMIT)
      |=> sample_reg[0] == 16'h3ffc)
    else $error("high-res clamp wrong");
  a_one_g_word: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sampleValid && mode == atof_pkg::ATOF_ONE_G && alarm == '0) |=> sample_reg[1] == $past(accY))
    else $error("one-g word wrong");
  a_hold_stable: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rdLow && slot_of(rdReq.rdAddr) == 2'h3 && !rdHigh) ##1 (rdLow && $stable(rdReq.rdAddr))
      |=> $stable(rdData))
    else $error("captured byte changed without high read");
  a_temp_top_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    sampleValid |=> sample_reg[3][15:14] == 2'h0)
    else $error("temperature top bits not zero");
endmodule

// [bench/atof_host_model.sv]
// Host controller model that issues register reads to the formatter
`timescale 1ns/1ps
module atof_host_model (
  input wire logic ref_clk,
  output atof_pkg::atof_rd_type rdReq
);
  // Idle: no strobe
  initial begin
    rdReq <= '0;
  end

  // Single read; the released address shows a changed pattern
  task automatic readOne(input logic [7:0] a);
    @(posedge ref_clk);
    rdReq <= '{1'b1, a};
    @(posedge ref_clk);
    rdReq <= '{1'b0, ~a};
  endtask

  // High byte first, low byte on the very next edge
  task automatic readPair(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge ref_clk);
    rdReq <= '{1'b1, hi};
    @(posedge ref_clk);
    rdReq <= '{1'b1, lo};
    @(posedge ref_clk);
    rdReq <= '{1'b0, ~lo};
  endtask
endmodule

// [bench/atof_formatter_tb.sv]
// Self-checking testbench for the output formatter
`timescale 1ns/1ps
module atof_formatter_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  atof_pkg::atof_mode_type mode;
  atof_pkg::atof_alarm_type alarm;
  logic sampleValid;
  logic signed [15:0] accX, accY, accZ;
  logic signed [13:0] tempRaw;
  atof_pkg::atof_rd_type rdReq;
  logic [7:0] rdData;
  logic rdValid;
  logic [15:0] expQ[$];
  logic [15:0] e;
  int nFail = 0;
  int testsRun = 0;

  // Clock, 25 ns period
  always #12.5 ref_clk = ~ref_clk;

  atof_formatter i_atof_formatter (.ref_clk(ref_clk), .nrst(nrst), .mode(mode), .alarm(alarm),
    .sampleValid(sampleValid), .accX(accX), .accY(accY), .accZ(accZ), .tempRaw(tempRaw),
    .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid));
  atof_host_model i_atof_host_model (.ref_clk(ref_clk), .rdReq(rdReq));

  // ----------------------------------------
  // Expected values
  // ----------------------------------------
  function automatic logic [15:0] accWord(atof_pkg::atof_mode_type m, atof_pkg::atof_alarm_type a,
                                          logic signed [15:0] v);
    logic signed [15:0] c;
    c = (v > 16'sh0fff) ? 16'sh0fff : ((v < -16'sh1000) ? -16'sh1000 : v);
    if (a.continuousSelftestFail || a.startupSelftestFail) return 16'hffff;
    if (a.checksumFail) return 16'h7fff;
    if (m == atof_pkg::ATOF_SIX_REDUCED) return {v[11:0], 4'h0};
    if (m == atof_pkg::ATOF_SIX_HIRES) return {c[13:0], 2'b00};
    return v;
  endfunction

  // Undefined low bits are ignored by the reader
  function automatic logic [15:0] accMask(atof_pkg::atof_mode_type m, atof_pkg::atof_alarm_type a);
    if (a != 3'h0 || m == atof_pkg::ATOF_ONE_G) return 16'hffff;
    return (m == atof_pkg::ATOF_SIX_REDUCED) ? 16'hfff0 : 16'hfffc;
  endfunction

  function automatic logic signed [15:0] rnd(atof_pkg::atof_mode_type m);
    logic [31:0] r;
    r = $urandom;
    if (m == atof_pkg::ATOF_SIX_REDUCED) return {{4{r[11]}}, r[11:0]};
    if (m == atof_pkg::ATOF_SIX_HIRES) return {{2{r[13]}}, r[13:0]};
    return r[15:0];
  endfunction

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic loadS(atof_pkg::atof_mode_type m, atof_pkg::atof_alarm_type a, logic signed [15:0] x,
                       logic signed [15:0] y, logic signed [15:0] z, logic [13:0] t);
    @(posedge ref_clk);
    mode <= m;
    alarm <= a;
    accX <= x;
    accY <= y;
    accZ <= z;
    tempRaw <= t;
    sampleValid <= 1'b1;
    @(posedge ref_clk);
    sampleValid <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] hi, input logic [15:0] w, input logic [15:0] mk);
    expQ.push_back({mk[15:8], w[15:8]});
    expQ.push_back({mk[7:0], w[7:0]});
    i_atof_host_model.readPair(hi, hi - 8'h01);
  endtask

  task automatic test(atof_pkg::atof_mode_type m, atof_pkg::atof_alarm_type a, logic signed [15:0] x,
                      logic signed [15:0] y, logic signed [15:0] z, logic [13:0] t);
    loadS(m, a, x, y, z, t);
    chk(8'h05, accWord(m, a, x), accMask(m, a));
    chk(8'h07, accWord(m, a, y), accMask(m, a));
    chk(8'h09, accWord(m, a, z), accMask(m, a));
    chk(8'h13, (m == atof_pkg::ATOF_SIX_HIRES) ? {2'b00, t[12:0], 1'b0} : {2'b00, t},
        (m == atof_pkg::ATOF_SIX_HIRES) ? 16'h3ffe : 16'h3fff);
    $display("test mode %0d alarm %0h done", m, a);
  endtask

  task giveVerdict;
    if (expQ.size() != 0) begin
      nFail++;
      $display("answers missing %0d", expQ.size());
    end
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Result monitor: oldest note against each answer
  always @(negedge ref_clk) begin
    if (rdValid === 1'b1) begin
      testsRun++;
      e = (expQ.size() > 0) ? expQ.pop_front() : 16'h00ff;
      if ((rdData & e[15:8]) !== (e[7:0] & e[15:8]) || e === 16'h00ff) begin
        nFail++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, rdData, e[7:0]);
      end
    end
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    nFail++;
    $display("watchdog expired");
    giveVerdict;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mode <= atof_pkg::ATOF_SIX_REDUCED;
    alarm <= '0;
    sampleValid <= 1'b0;
    accX <= '0;
    accY <= '0;
    accZ <= '0;
    tempRaw <= '0;
    void'($urandom(32'hc4dd7bab));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(8'h13, 16'h0000, 16'hffff);
    expQ.push_back(16'hff00);
    i_atof_host_model.readOne({2'b01, 6'($urandom)});
    $display("test reset done");
    test(atof_pkg::ATOF_SIX_REDUCED, '0, 16'sh0145, -16'sh0145, 16'sh07ff, 14'h3fff);
    test(atof_pkg::ATOF_SIX_HIRES, '0, 16'sh1388, -16'sh1388, 16'sh028a, 14'h1000);
    test(atof_pkg::ATOF_ONE_G, '0, 16'sh7d00, -16'sh7d00, 16'sh8000, 14'h0000);
    for (int k = 0; k < 12; k++) begin
      atof_pkg::atof_alarm_type ra;
      ra = (k < 9) ? 3'h0 : 3'($urandom);
      test(atof_pkg::atof_mode_type'(k % 3), ra, rnd(atof_pkg::atof_mode_type'(k % 3)),
           rnd(atof_pkg::atof_mode_type'(k % 3)), rnd(atof_pkg::atof_mode_type'(k % 3)), 14'($urandom) & 14'h1fff);
    end
    for (int k = 0; k < 3; k++) begin
      test(atof_pkg::ATOF_SIX_HIRES, atof_pkg::atof_alarm_type'(3'h1 << k), 16'sh0010, 16'sh0020, 16'sh0030, 14'h0100);
    end
    // Reset in mid-run: result bytes return to zero
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(8'h13, 16'h0000, 16'hffff);
    $display("test mid reset done");
    loadS(atof_pkg::ATOF_SIX_REDUCED, '0, 16'sh0123, 16'sh0000, 16'sh0000, 14'h2a5c);
    expQ.push_back(16'hff12);
    i_atof_host_model.readOne(8'h05);
    expQ.push_back(16'hff2a);
    i_atof_host_model.readOne(8'h13);
    loadS(atof_pkg::ATOF_SIX_REDUCED, '0, 16'sh0456, 16'sh0000, 16'sh0000, 14'h0111);
    expQ.push_back(16'hf030);
    i_atof_host_model.readOne(8'h04);
    expQ.push_back(16'hff5c);
    expQ.push_back(16'hff5c);
    i_atof_host_model.readPair(8'h12, 8'h12);
    $display("test hold done");
    repeat (4) @(posedge ref_clk);
    giveVerdict;
  end
endmodule
